// file: rtl/pressure_sensor_config_regs.sv
// Operation
// - Reference pressure, 24-bit two's complement, is added to each raw pressure.
// - Four-bit pressure averaging code selects 1 to 512 samples.
// - Three-bit temperature averaging code selects 1 to 128 samples.
// - Averaging register resets to 7A; its top bit is reserved.
// - Top bit of control one: zero powers down, one runs.
// - Three-bit rate code selects one-shot or the listed periodic rates.
// - Differential circuit stays off and outputs zero until enabled.
// - Lowest control bit picks four-wire or three-wire serial wiring.
// - Calibration content reloads automatically at power-up.
// - Registers are selected by a seven-bit address from the serial link.
// - Sub-address top bit enables address advance after every byte.
// - In one-shot mode the start bit runs one conversion, then self-clears.
module pressure_sensor_config_regs
  import pressure_regs_pkg::*;
#(
  parameter logic [7:0] P_IDENTITY = 8'h5A, // Arbitrary value.
  parameter int         P_CYC_1HZ  = pressure_regs_pkg::PER_1HZ_NS
                                     / pressure_regs_pkg::CLK_PERIOD_NS,
  parameter int         P_CYC_7HZ  = pressure_regs_pkg::PER_7HZ_NS
                                     / pressure_regs_pkg::CLK_PERIOD_NS,
  parameter int         P_CYC_12HZ = pressure_regs_pkg::PER_12HZ_NS
                                     / pressure_regs_pkg::CLK_PERIOD_NS,
  parameter int         P_CYC_25HZ = pressure_regs_pkg::PER_25HZ_NS
                                     / pressure_regs_pkg::CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                        I_CLK,
  input  wire logic                        I_RST_B,
  // Byte side of the serial engine.
  input  wire pressure_regs_pkg::reg_req_t I_REG_REQ,
  output logic [7:0]                       O_RD_DATA,
  // Measurement path.
  input  wire pressure_regs_pkg::sample_t  I_SAMPLE,
  input  wire logic [7:0]                  I_CALIB,
  output logic                             O_CONV_START,
  output logic                             O_CONV_TEMP,
  output logic [9:0]                       O_PRESS_AVG_N,
  output logic [7:0]                       O_TEMP_AVG_N,
  // Mode outputs.
  output logic                             O_ACTIVE,
  output logic                             O_THREE_WIRE,
  output logic                             O_DIFF_ON,
  output logic [23:0]                      O_DIFF_PRESS,
  output logic [7:0]                       O_AFE_CTRL
);
  import pressure_regs_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [23:0] ref_press;
    logic [7:0]  avg;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  ctrl3;
    logic [7:0]  int_cfg;
    logic [15:0] ths;
    logic [7:0]  status;
    logic [23:0] press_out;
    logic [15:0] temp_out;
    logic [7:0]  afe;
    logic        boot_pend;
    logic [6:0]  addr;
    logic        inc;
    logic [7:0]  rd_data;
    conv_state_t conv;
    logic        shot;
    logic        temp_pend;
    logic        temp_due;
    logic        conv_start;
    logic        conv_temp;
    logic        p_lo_seen;
    logic        p_hi_seen;
    logic        t_lo_seen;
    logic        t_hi_seen;
    logic [23:0] diff_press;
    logic [9:0]  press_avg_n;
    logic [7:0]  temp_avg_n;
  } regs_t;

  regs_t              state_q;
  regs_t              state_d;
  logic               p_tick;
  logic               t_tick;
  logic               timers_run;
  logic [2:0]         rate;
  logic [TIMER_W-1:0] p_period;
  logic [TIMER_W-1:0] t_period;
  logic [23:0]        press_sum;
  logic               p_free;
  logic               t_free;

  assign rate       = state_q.ctrl1[RATE_MSB:RATE_LSB];
  assign timers_run = state_q.ctrl1[ACTIVE_BIT] && (rate != RATE_SHOT);
  assign press_sum  = I_SAMPLE.press + state_q.ref_press;
  assign p_free     = !(state_q.ctrl1[HOLD_BIT] && (state_q.p_lo_seen || state_q.p_hi_seen));
  assign t_free     = !(state_q.ctrl1[HOLD_BIT] && (state_q.t_lo_seen || state_q.t_hi_seen));

  // ****************************************************************
  // Rate decode and timers.
  // ****************************************************************
  // Pressure and temperature keep separate timers because their rates need not divide.
  always_comb begin
    unique case (rate)
      RATE_1_1:              p_period = TIMER_W'(P_CYC_1HZ);
      RATE_7_1, RATE_7_7:    p_period = TIMER_W'(P_CYC_7HZ);
      RATE_12_1, RATE_12_12: p_period = TIMER_W'(P_CYC_12HZ);
      RATE_25_1, RATE_25_25: p_period = TIMER_W'(P_CYC_25HZ);
      default:               p_period = TIMER_W'(P_CYC_1HZ);
    endcase
    unique case (rate)
      RATE_7_7:   t_period = TIMER_W'(P_CYC_7HZ);
      RATE_12_12: t_period = TIMER_W'(P_CYC_12HZ);
      RATE_25_25: t_period = TIMER_W'(P_CYC_25HZ);
      default:    t_period = TIMER_W'(P_CYC_1HZ);
    endcase
  end

  rate_timer #(.W(TIMER_W)) u_press_timer (
    .i_clk    (I_CLK),
    .i_rst_b  (I_RST_B),
    .i_run    (timers_run),
    .i_period (p_period),
    .o_tick   (p_tick)
  );

  rate_timer #(.W(TIMER_W)) u_temp_timer (
    .i_clk    (I_CLK),
    .i_rst_b  (I_RST_B),
    .i_run    (timers_run),
    .i_period (t_period),
    .o_tick   (t_tick)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Order matters: read clears, then sample sets, then host writes, so sets win.
  always_comb begin
    logic lo;
    logic hi;
    lo      = 1'b0;
    hi      = 1'b0;
    state_d = state_q;
    state_d.conv_start = 1'b0;
    // Calibration copy at power-up or on a reboot request.
    if (state_q.boot_pend || state_q.ctrl2[BOOT_BIT]) begin
      state_d.afe             = I_CALIB;
      state_d.boot_pend       = 1'b0;
      state_d.ctrl2[BOOT_BIT] = 1'b0;
    end
    // Read side effects: data-ready clear and the hold bookkeeping.
    if (I_REG_REQ.rd_stb && !I_REG_REQ.txn_start) begin
      lo = (state_q.addr == ADDR_P_LOW) || (state_q.addr == ADDR_P_MID);
      hi = state_q.addr == ADDR_P_HIGH;
      if (hi) begin
        state_d.status[P_AVAIL_BIT] = 1'b0;
        state_d.status[P_OVER_BIT]  = 1'b0;
      end
      if (state_q.addr == ADDR_T_HIGH) begin
        state_d.status[T_AVAIL_BIT] = 1'b0;
        state_d.status[T_OVER_BIT]  = 1'b0;
      end
      state_d.p_lo_seen = state_q.p_lo_seen || lo;
      state_d.p_hi_seen = state_q.p_hi_seen || hi;
      state_d.t_lo_seen = state_q.t_lo_seen || (state_q.addr == ADDR_T_LOW);
      state_d.t_hi_seen = state_q.t_hi_seen || (state_q.addr == ADDR_T_HIGH);
    end
    if ((state_d.p_lo_seen && state_d.p_hi_seen) || !state_q.ctrl1[HOLD_BIT]) begin
      state_d.p_lo_seen = 1'b0;
      state_d.p_hi_seen = 1'b0;
    end
    if ((state_d.t_lo_seen && state_d.t_hi_seen) || !state_q.ctrl1[HOLD_BIT]) begin
      state_d.t_lo_seen = 1'b0;
      state_d.t_hi_seen = 1'b0;
    end
    // Temperature due flag survives until the next periodic pressure start takes it.
    if (t_tick) begin
      state_d.temp_due = 1'b1;
    end
    unique case (state_q.conv)
      CONV_IDLE: begin
        if (state_q.ctrl1[ACTIVE_BIT] && rate == RATE_SHOT && state_q.ctrl2[SHOT_BIT]) begin
          state_d.conv       = CONV_BUSY;
          state_d.shot       = 1'b1;
          state_d.conv_start = 1'b1;
          state_d.conv_temp  = 1'b1;
          state_d.temp_pend  = 1'b1;
        end else if (timers_run && p_tick) begin
          state_d.conv       = CONV_BUSY;
          state_d.shot       = 1'b0;
          state_d.conv_start = 1'b1;
          state_d.conv_temp  = state_q.temp_due || t_tick;
          state_d.temp_pend  = state_q.temp_due || t_tick;
          state_d.temp_due   = 1'b0;
        end
      end
      CONV_BUSY: begin
        if (I_SAMPLE.done) begin
          state_d.conv = CONV_IDLE;
          if (state_q.shot) begin
            state_d.ctrl2[SHOT_BIT] = 1'b0;
          end
          // A held output drops the new sample rather than tear a pair.
          if (p_free) begin
            state_d.press_out           = press_sum;
            state_d.status[P_OVER_BIT]  = state_d.status[P_OVER_BIT]
                                          | state_q.status[P_AVAIL_BIT];
            state_d.status[P_AVAIL_BIT] = 1'b1;
          end
          if (state_q.temp_pend && t_free) begin
            state_d.temp_out            = I_SAMPLE.temp;
            state_d.status[T_OVER_BIT]  = state_d.status[T_OVER_BIT]
                                          | state_q.status[T_AVAIL_BIT];
            state_d.status[T_AVAIL_BIT] = 1'b1;
          end
          if (state_q.ctrl1[DIFF_BIT]) begin
            state_d.diff_press = press_sum;
          end
        end
      end
    endcase
    if (!state_q.ctrl1[DIFF_BIT]) begin
      state_d.diff_press = '0;
    end
    // Host write; unlisted and reserved addresses swallow the byte.
    if (I_REG_REQ.wr_stb && !I_REG_REQ.txn_start) begin
      unique case (state_q.addr)
        ADDR_REF_LOW:  state_d.ref_press[7:0]   = I_REG_REQ.wr_data;
        ADDR_REF_MID:  state_d.ref_press[15:8]  = I_REG_REQ.wr_data;
        ADDR_REF_HIGH: state_d.ref_press[23:16] = I_REG_REQ.wr_data;
        ADDR_AVG_CFG:  state_d.avg = I_REG_REQ.wr_data & AVG_WR_MASK;
        ADDR_CTRL_ONE: state_d.ctrl1 = I_REG_REQ.wr_data;
        ADDR_CTRL_TWO: state_d.ctrl2 = I_REG_REQ.wr_data;
        ADDR_CTRL_THR: state_d.ctrl3 = I_REG_REQ.wr_data;
        ADDR_INT_CFG:  state_d.int_cfg = I_REG_REQ.wr_data;
        ADDR_THS_LOW:  state_d.ths[7:0] = I_REG_REQ.wr_data;
        ADDR_THS_HIGH: state_d.ths[15:8] = I_REG_REQ.wr_data;
        ADDR_AFE_CTRL: state_d.afe = I_REG_REQ.wr_data;
        default:       state_d.afe = state_d.afe;
      endcase
    end
    // Read mux works on the current address, before it advances.
    if (I_REG_REQ.rd_stb && !I_REG_REQ.txn_start) begin
      unique case (state_q.addr)
        ADDR_REF_LOW:   state_d.rd_data = state_q.ref_press[7:0];
        ADDR_REF_MID:   state_d.rd_data = state_q.ref_press[15:8];
        ADDR_REF_HIGH:  state_d.rd_data = state_q.ref_press[23:16];
        ADDR_IDENTITY:  state_d.rd_data = P_IDENTITY;
        ADDR_AVG_CFG:   state_d.rd_data = state_q.avg;
        ADDR_CTRL_ONE:  state_d.rd_data = state_q.ctrl1;
        ADDR_CTRL_TWO:  state_d.rd_data = state_q.ctrl2;
        ADDR_CTRL_THR:  state_d.rd_data = state_q.ctrl3;
        ADDR_INT_CFG:   state_d.rd_data = state_q.int_cfg;
        ADDR_INT_FLAGS: state_d.rd_data = BYTE_ZERO;
        ADDR_THS_LOW:   state_d.rd_data = state_q.ths[7:0];
        ADDR_THS_HIGH:  state_d.rd_data = state_q.ths[15:8];
        ADDR_STATUS:    state_d.rd_data = state_q.status;
        ADDR_P_LOW:     state_d.rd_data = state_q.press_out[7:0];
        ADDR_P_MID:     state_d.rd_data = state_q.press_out[15:8];
        ADDR_P_HIGH:    state_d.rd_data = state_q.press_out[23:16];
        ADDR_T_LOW:     state_d.rd_data = state_q.temp_out[7:0];
        ADDR_T_HIGH:    state_d.rd_data = state_q.temp_out[15:8];
        ADDR_AFE_CTRL:  state_d.rd_data = state_q.afe;
        default:        state_d.rd_data = BYTE_ZERO;
      endcase
    end
    // Address load at the start of a transfer, advance after each byte when the increment bit was set.
    if (I_REG_REQ.txn_start) begin
      state_d.addr = I_REG_REQ.sub_addr[6:0];
      state_d.inc  = I_REG_REQ.sub_addr[SUB_INC_BIT];
    end else if ((I_REG_REQ.rd_stb || I_REG_REQ.wr_stb) && state_q.inc) begin
      state_d.addr = state_q.addr + 7'h01;
    end
    state_d.press_avg_n = press_avg_count(state_d.avg[3:0]);
    state_d.temp_avg_n  = temp_avg_count(state_d.avg[6:4]);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q             <= '0;
      state_q.avg         <= AVG_RESET;
      state_q.conv        <= CONV_IDLE;
      state_q.boot_pend   <= 1'b1;
      state_q.press_avg_n <= press_avg_count(AVG_RESET[3:0]);
      state_q.temp_avg_n  <= temp_avg_count(AVG_RESET[6:4]);
    end else begin
      state_q <= state_d;
    end
  end

  assign O_RD_DATA     = state_q.rd_data;
  assign O_CONV_START  = state_q.conv_start;
  assign O_CONV_TEMP   = state_q.conv_temp;
  assign O_PRESS_AVG_N = state_q.press_avg_n;
  assign O_TEMP_AVG_N  = state_q.temp_avg_n;
  assign O_ACTIVE      = state_q.ctrl1[ACTIVE_BIT];
  assign O_THREE_WIRE  = state_q.ctrl1[WIRE_BIT];
  assign O_DIFF_ON     = state_q.ctrl1[DIFF_BIT];
  assign O_DIFF_PRESS  = state_q.diff_press;
  assign O_AFE_CTRL    = state_q.afe;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  logic rd_any;
  assign rd_any = I_REG_REQ.rd_stb && !I_REG_REQ.txn_start;

  a_ref_sum_out: assert property (state_q.conv == CONV_BUSY && I_SAMPLE.done && p_free
    |=> state_q.press_out == $past(press_sum))
    else $error("pressure output not raw plus reference");
  a_avg_press: assert property (##1 O_PRESS_AVG_N == press_avg_count(state_q.avg[3:0]))
    else $error("pressure averaging count wrong");
  a_avg_temp: assert property (##1 O_TEMP_AVG_N == temp_avg_count(state_q.avg[6:4]))
    else $error("temperature averaging count wrong");
  a_avg_reset: assert property ($rose(I_RST_B) |-> state_q.avg == AVG_RESET && !state_q.avg[7])
    else $error("averaging register reset value wrong");
  a_down_quiet: assert property (!O_ACTIVE && !$past(O_ACTIVE) |-> !O_CONV_START)
    else $error("conversion started while powered down");
  a_diff_off: assert property (!O_DIFF_ON |=> O_DIFF_PRESS == 24'h000000)
    else $error("differential output live while off");
  a_hold_freeze: assert property (state_q.ctrl1[HOLD_BIT] && state_q.p_lo_seen
    && !rd_any && !(I_REG_REQ.wr_stb) |=> $stable(state_q.press_out))
    else $error("held pressure output changed");
  a_wire_mode: assert property (O_THREE_WIRE == state_q.ctrl1[0])
    else $error("wiring select not from control bit");
  a_ident_read: assert property (rd_any && state_q.addr == ADDR_IDENTITY
    |=> O_RD_DATA == P_IDENTITY)
    else $error("identity read wrong");
  a_addr_adv: assert property (rd_any && state_q.inc |=> state_q.addr == $past(state_q.addr) + 7'h01)
    else $error("address did not advance");
  a_shot_clear: assert property (state_q.conv == CONV_BUSY && state_q.shot && I_SAMPLE.done
    && !I_REG_REQ.wr_stb |=> !state_q.ctrl2[SHOT_BIT] && state_q.status[P_AVAIL_BIT])
    else $error("one-shot not completed");
  a_shot_temp: assert property (O_CONV_START && rate == RATE_SHOT |-> O_CONV_TEMP)
    else $error("one-shot without temperature");

  c_one_shot: cover property (O_CONV_START && state_q.shot);
  c_periodic: cover property (O_CONV_START && !state_q.shot);
  c_hold_drop: cover property (state_q.conv == CONV_BUSY && I_SAMPLE.done && !p_free);
  c_burst_read: cover property (rd_any && state_q.inc ##1 rd_any);

endmodule // pressure_sensor_config_regs

// file: rtl/pressure_regs_pkg.sv
package pressure_regs_pkg;

  // ****************************************************************
  // Register addresses, seven bits wide.
  // ****************************************************************
  localparam logic [6:0] ADDR_REF_LOW   = 7'h08;
  localparam logic [6:0] ADDR_REF_MID   = 7'h09;
  localparam logic [6:0] ADDR_REF_HIGH  = 7'h0A;
  localparam logic [6:0] ADDR_IDENTITY  = 7'h0F;
  localparam logic [6:0] ADDR_AVG_CFG   = 7'h10;
  localparam logic [6:0] ADDR_CTRL_ONE  = 7'h20;
  localparam logic [6:0] ADDR_CTRL_TWO  = 7'h21;
  localparam logic [6:0] ADDR_CTRL_THR  = 7'h22;
  localparam logic [6:0] ADDR_INT_CFG   = 7'h23;
  localparam logic [6:0] ADDR_INT_FLAGS = 7'h24;
  localparam logic [6:0] ADDR_THS_LOW   = 7'h25;
  localparam logic [6:0] ADDR_THS_HIGH  = 7'h26;
  localparam logic [6:0] ADDR_STATUS    = 7'h27;
  localparam logic [6:0] ADDR_P_LOW     = 7'h28;
  localparam logic [6:0] ADDR_P_MID     = 7'h29;
  localparam logic [6:0] ADDR_P_HIGH    = 7'h2A;
  localparam logic [6:0] ADDR_T_LOW     = 7'h2B;
  localparam logic [6:0] ADDR_T_HIGH    = 7'h2C;
  localparam logic [6:0] ADDR_AFE_CTRL  = 7'h30;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int         SUB_INC_BIT    = 7;
  localparam int         ACTIVE_BIT     = 7;
  localparam int         RATE_MSB       = 6;
  localparam int         RATE_LSB       = 4;
  localparam int         DIFF_BIT       = 3;
  localparam int         HOLD_BIT       = 2;
  localparam int         WIRE_BIT       = 0;
  localparam int         BOOT_BIT       = 7;
  localparam int         SHOT_BIT       = 0;
  localparam int         T_AVAIL_BIT    = 0;
  localparam int         P_AVAIL_BIT    = 1;
  localparam int         T_OVER_BIT     = 4;
  localparam int         P_OVER_BIT     = 5;
  localparam logic [7:0] AVG_RESET      = 8'h7A;
  localparam logic [7:0] AVG_WR_MASK    = 8'h7F;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // ****************************************************************
  // Rate codes and sample periods.
  // ****************************************************************
  localparam logic [2:0] RATE_SHOT      = 3'h0;
  localparam logic [2:0] RATE_1_1       = 3'h1;
  localparam logic [2:0] RATE_7_1       = 3'h2;
  localparam logic [2:0] RATE_12_1      = 3'h3;
  localparam logic [2:0] RATE_25_1      = 3'h4;
  localparam logic [2:0] RATE_7_7       = 3'h5;
  localparam logic [2:0] RATE_12_12     = 3'h6;
  localparam logic [2:0] RATE_25_25     = 3'h7;
  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         PER_1HZ_NS     = 1000000000;
  localparam int         PER_7HZ_NS     = 142857142;
  localparam int         PER_12HZ_NS    = 80000000;
  localparam int         PER_25HZ_NS    = 40000000;
  localparam int         TIMER_W        = 24;

  // ****************************************************************
  // Carriers and states.
  // ****************************************************************
  typedef struct packed {
    logic       txn_start;
    logic [7:0] sub_addr;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic       rd_stb;
  } reg_req_t;

  typedef struct packed {
    logic        done;
    logic [23:0] press;
    logic [15:0] temp;
  } sample_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } conv_state_t;

  // Pressure averaging count; unlisted codes saturate at the largest count.
  function automatic logic [9:0] press_avg_count(input logic [3:0] code);
    if (code <= 4'h8) begin
      press_avg_count = 10'h001 << code;
    end else if (code == 4'h9) begin
      press_avg_count = 10'h180;
    end else begin
      press_avg_count = 10'h200;
    end
  endfunction

  function automatic logic [7:0] temp_avg_count(input logic [2:0] code);
    temp_avg_count = 8'h01 << code;
  endfunction

endpackage

// file: rtl/rate_timer.sv
module rate_timer #(
  parameter int W = 24
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Control.
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_period,
  // Tick.
  output logic              o_tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } timer_t;

  timer_t tmr_q;
  timer_t tmr_d;

  // A stopped timer restarts from zero, so the first tick is one full period late.
  always_comb begin
    tmr_d      = tmr_q;
    tmr_d.tick = 1'b0;
    if (!i_run) begin
      tmr_d.cnt = '0;
    end else if (tmr_q.cnt >= i_period - 1'b1) begin
      tmr_d.cnt  = '0;
      tmr_d.tick = 1'b1;
    end else begin
      tmr_d.cnt = tmr_q.cnt + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  assign o_tick = tmr_q.tick;

endmodule // rate_timer

// file: bench/sample_source.sv
module sample_source
  import pressure_regs_pkg::*;
(
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // Conversion request, latency and raw values.
  input  wire logic                       i_start,
  input  wire logic [31:0]                i_lat,
  input  wire logic [23:0]                i_press,
  input  wire logic [15:0]                i_temp,
  // Result towards the register bank.
  output pressure_regs_pkg::sample_t      o_smp
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  // Answers i_lat cycles after a start; outside a result the data lines churn,
  // so a stale value can never pass for a fresh one.
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_smp <= '0;
    end else begin
      o_smp <= '{1'b0, ~o_smp.press, ~o_smp.temp};
      if (i_start) begin
        cnt <= i_lat;
      end else if (cnt == 1) begin
        o_smp <= '{1'b1, i_press, i_temp};
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // sample_source

// file: bench/tb_pressure_sensor_config_regs.sv
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_pressure_sensor_config_regs
  import pressure_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value.
  logic I_CLK, I_RST_B, st, ctemp, act, tw, don;
  reg_req_t req;
  sample_t smp;
  logic [7:0] rd, calib, tn, afe, q;
  logic [9:0] pn;
  logic [23:0] dp, raw, rf;
  logic [15:0] rt;
  logic [39:0] ev;
  int lat, err_total, n_compared, seed, t0, t1;
  int per[8] = '{0, 50, 30, 20, 10, 30, 20, 10};

  pressure_sensor_config_regs #(.P_IDENTITY(ID), .P_CYC_1HZ(50), .P_CYC_7HZ(30),
    .P_CYC_12HZ(20), .P_CYC_25HZ(10)) DUT (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_REG_REQ(req), .O_RD_DATA(rd), .I_SAMPLE(smp), .I_CALIB(calib),
    .O_CONV_START(st), .O_CONV_TEMP(ctemp), .O_PRESS_AVG_N(pn), .O_TEMP_AVG_N(tn),
    .O_ACTIVE(act), .O_THREE_WIRE(tw), .O_DIFF_ON(don), .O_DIFF_PRESS(dp),
    .O_AFE_CTRL(afe));
  sample_source u_src (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_start(st), .i_lat(lat),
    .i_press(raw), .i_temp(rt), .o_smp(smp));

  // ****************************************************************
  // Bus tasks: one request per call, released after the taking edge.
  // ****************************************************************
  task automatic acc(input int k, input logic [7:0] v);
    @(posedge I_CLK);
    #10 req = '{k == 0, v, k == 1, v, k == 2};
    @(posedge I_CLK);
    #10 req = '0;
    q = rd;
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    acc(0, {1'b0, a});
    acc(1, d);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    acc(0, {1'b0, a});
    acc(2, 8'h00);
    `CMP(q, e)
  endtask
  task automatic wstart(output int t);
    t = -1;
    for (int i = 0; i < 200 && t < 0; i++) begin
      @(posedge I_CLK);
      #1 if (st === 1'b1) t = $time / 100;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Clock of 100 ns period; the watchdog cuts a hang short.
  initial begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end
  initial begin
    #(4000 * 100) err_total++;
    conclude;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    seed = 32'h6CE113F9;
    {I_RST_B, req, lat, err_total, n_compared} = '0;
    calib = $random(seed);
    raw = $random(seed);
    rt = $random(seed);
    rf = $random(seed);
    repeat (3) @(posedge I_CLK);
    #10 I_RST_B = 1'b1;
    @(posedge I_CLK);
    #10 `CMP(afe, calib)
    `CMP({pn, tn}, {10'h200, 8'h80})
    acc(0, 8'h8F);
    acc(2, 8'h00);
    `CMP(q, ID)
    acc(2, 8'h00);
    `CMP(q, 8'h7A)
    wreg(7'h0F, 8'h00);
    rchk(7'h0F, ID);
    wreg(7'h10, 8'hFF);
    rchk(7'h10, 8'h7F);
    for (int c = 0; c < 11; c++) begin
      wreg(7'h10, {1'b0, c[2:0], c[3:0]});
      @(posedge I_CLK);
      #10 `CMP(pn, c < 9 ? 10'(1 << c) : (c == 9 ? 10'h180 : 10'h200))
      `CMP(tn, 8'(1 << c[2:0]))
    end
    // Reference first, circuit enabled afterwards.
    acc(0, 8'h88);
    acc(1, rf[7:0]);
    acc(1, rf[15:8]);
    acc(1, rf[23:16]);
    wreg(7'h20, 8'h09);
    rchk(7'h20, 8'h09);
    `CMP({act, tw, don}, 3'b011)
    wreg(7'h20, 8'h89);
    lat = 3;
    wreg(7'h21, 8'h01);
    wstart(t0);
    `CMP({act, ctemp}, 2'b11)
    repeat (6) @(posedge I_CLK);
    #10 `CMP(dp, 24'(raw + rf))
    rchk(7'h27, 8'h03);
    rchk(7'h21, 8'h00);
    ev = {rt, 24'(raw + rf)};
    acc(0, 8'hA8);
    for (int i = 0; i < 5; i++) begin
      acc(2, 8'h00);
      `CMP(q, ev[8 * i +: 8])
    end
    wreg(7'h20, 8'h80);
    @(posedge I_CLK);
    #10 `CMP({dp, tw, don}, 26'h0)
    lat = 1;
    wreg(7'h10, 8'h6A);
    for (int r = 1; r < 8; r++) begin
      wreg(7'h20, {1'b0, 3'(r - 1), 4'h0});
      wreg(7'h20, {1'b0, r[2:0], 4'h0});
      wreg(7'h20, {1'b1, r[2:0], 4'h0});
      wstart(t0);
      wstart(t1);
      `CMP(t1 - t0, per[r])
    end
    conclude;
  end
endmodule // tb_pressure_sensor_config_regs
